// File: src/ret_timer_two.sv
// Second event-driven down-counting timer with its APB register slave.
// Assumes the frame and field inputs come from logic on clock; the contactless
// clock is a pin and is sampled through three flip-flops.
//
// Functional notes
// R1 - Halt bit set: stop the timer once a received frame shows 4 bits.
// R2 - Halt bit set: stop the timer when transmission begins.
// R3 - Halt bit set: stop the timer when an external field appears.
// R4 - Halt bit set: stop the timer when the external field disappears.
// R5 - Halt bits set: stop the timer when own field switches on or off.
// R6 - Go bit set: start the timer on the first received bit.
// R7 - Go bit set: start the timer when reception ends.
// R8 - Go bit set: start the timer when transmission begins.
// R9 - Go bit set: start the timer when transmission ends.
// R10 - Go bit set: start the timer when an external field appears.
// R11 - Go bit set: start the timer when the external field is lost.
// R12 - Go bits set: start the timer when own field switches on or off.
// R13 - Immediate-start bit starts the timer at once.
// R14 - Three-bit divider select: 6.78 MHz at 000b halving down to 53 kHz.
// R15 - Source bit clear counts at 13.56 MHz; set uses divided rate.
// R16 - Reload clear: on expiry stop and hold counter at zero.
// R17 - Reload set: on expiry reload preset and keep counting.
// R18 - Timer works only while enabled; all configuration resets to zero.
// R19 - Expiry is the counter reaching zero and is reported to status.
// R20 - Events sampled on the timer clock; stop beats start in one cycle.
module ret_timer_two
#(
    parameter int COUNT_W = ret_pkg::COUNT_W_DEFAULT
)
(
    input wire logic clock,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic contactless_interface_clock,
    input wire logic rx_first_bit,
    input wire logic rx_four_bits,
    input wire logic rx_done,
    input wire logic tx_begin,
    input wire logic tx_done,
    input wire logic external_field,
    input wire logic own_field,
    output logic timer_running,
    output logic timer_expired,
    output logic [COUNT_W-1:0] timer_value
);
    import ret_pkg::*;

    logic [31:0] config_ff;
    logic [COUNT_W-1:0] preset_ff;
    logic [COUNT_W-1:0] count_ff;
    logic running_ff;
    logic expired_sticky_ff;
    logic expire_pulse_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [2:0] cl_sync_ff;
    logic cl_level_ff;
    logic [DIV_W-1:0] div_ff;
    logic ext_prev_ff;
    logic own_prev_ff;
    logic go_now_ff;

    logic setup_phase;
    logic wr_access;
    logic addr_known;
    logic cl_rise;
    logic [DIV_W-1:0] div_mask;
    logic div_tick;
    logic tick;
    logic ext_on;
    logic ext_off;
    logic own_on;
    logic own_off;
    logic halt_event;
    logic go_event;
    logic expiring;
    logic [COUNT_W-1:0] nxt_count;
    logic nxt_running;

    // Requests are decoded in the setup cycle so that the answer is registered
    // and ready in the first access cycle.
    assign setup_phase = psel && !penable;
    assign wr_access = psel && penable && pwrite && pready_ff;
    assign addr_known = (paddr == ADDR_CONFIG) || (paddr == ADDR_PRESET)
        || (paddr == ADDR_VALUE) || (paddr == ADDR_STATUS);

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end
        else
        begin
            pready_ff <= setup_phase;
            pslverr_ff <= setup_phase && !addr_known;
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            prdata_ff <= 32'h0000_0000;
        end
        else if (setup_phase && !pwrite)
        begin
            case (paddr)
                ADDR_CONFIG: prdata_ff <= config_ff;
                ADDR_PRESET: prdata_ff <= 32'(preset_ff);
                ADDR_VALUE: prdata_ff <= 32'(count_ff);
                ADDR_STATUS:
                begin
                    prdata_ff <= 32'h0000_0000;
                    prdata_ff[STAT_RUNNING_BIT] <= running_ff;
                    prdata_ff[STAT_EXPIRED_BIT] <= expired_sticky_ff;
                end
                default: prdata_ff <= 32'h0000_0000;
            endcase
        end
        else if (setup_phase)
        begin
            prdata_ff <= 32'h0000_0000;
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            config_ff <= CONFIG_RESET; // [R18]
            preset_ff <= PRESET_RESET[COUNT_W-1:0];
        end
        else if (wr_access && paddr == ADDR_CONFIG)
        begin
            config_ff <= pwdata & CONFIG_MASK;
        end
        else if (wr_access && paddr == ADDR_PRESET)
        begin
            preset_ff <= pwdata[COUNT_W-1:0];
        end
    end

    // A write that sets the immediate-start bit is one start event.
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            go_now_ff <= 1'b0;
        end
        else
        begin
            go_now_ff <= wr_access && (paddr == ADDR_CONFIG) && pwdata[GO_NOW_BIT]; // [R13]
        end
    end

    // The contactless clock is sampled on three flops; an edge counts once the
    // second and third agree.
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            cl_sync_ff <= 3'b000;
            cl_level_ff <= 1'b0;
        end
        else
        begin
            cl_sync_ff <= {cl_sync_ff[1:0], contactless_interface_clock};
            if (cl_sync_ff[1] == cl_sync_ff[2])
            begin
                cl_level_ff <= cl_sync_ff[2];
            end
        end
    end

    assign cl_rise = (cl_sync_ff[1] == cl_sync_ff[2]) && cl_sync_ff[2] && !cl_level_ff;

    // Divider select n ticks once every 2^(n+1) contactless cycles.
    assign div_mask = DIV_W'((9'h002 << config_ff[DIV_SEL_HI:DIV_SEL_LO]) - 9'h001); // [R14]
    assign div_tick = cl_rise && ((div_ff & div_mask) == div_mask);
    assign tick = config_ff[SOURCE_SEL_BIT] ? div_tick : cl_rise; // [R15]

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            div_ff <= '0;
        end
        else if (!config_ff[ENABLE_BIT])
        begin
            div_ff <= '0;
        end
        else if (cl_rise)
        begin
            div_ff <= div_ff + DIV_W'(1);
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            ext_prev_ff <= 1'b0;
            own_prev_ff <= 1'b0;
        end
        else
        begin
            ext_prev_ff <= external_field;
            own_prev_ff <= own_field;
        end
    end

    assign ext_on = external_field && !ext_prev_ff;
    assign ext_off = !external_field && ext_prev_ff;
    assign own_on = own_field && !own_prev_ff;
    assign own_off = !own_field && own_prev_ff;

    assign halt_event = (config_ff[HALT_RX_BEGIN_BIT] && rx_four_bits) // [R1]
        || (config_ff[HALT_TX_BEGIN_BIT] && tx_begin) // [R2]
        || (config_ff[HALT_EXT_ON_BIT] && ext_on) // [R3]
        || (config_ff[HALT_EXT_OFF_BIT] && ext_off) // [R4]
        || (config_ff[HALT_OWN_ON_BIT] && own_on) // [R5]
        || (config_ff[HALT_OWN_OFF_BIT] && own_off); // [R5]

    assign go_event = (config_ff[GO_RX_BEGIN_BIT] && rx_first_bit) // [R6]
        || (config_ff[GO_RX_END_BIT] && rx_done) // [R7]
        || (config_ff[GO_TX_BEGIN_BIT] && tx_begin) // [R8]
        || (config_ff[GO_TX_END_BIT] && tx_done) // [R9]
        || (config_ff[GO_EXT_ON_BIT] && ext_on) // [R10]
        || (config_ff[GO_EXT_OFF_BIT] && ext_off) // [R11]
        || (config_ff[GO_OWN_ON_BIT] && own_on) // [R12]
        || (config_ff[GO_OWN_OFF_BIT] && own_off) // [R12]
        || go_now_ff; // [R13]

    assign expiring = running_ff && tick && (count_ff <= COUNT_W'(1)); // [R19]

    always_comb
    begin
        nxt_count = count_ff;
        nxt_running = running_ff;
        if (!config_ff[ENABLE_BIT])
        begin
            nxt_running = 1'b0; // [R18]
        end
        else if (halt_event)
        begin
            nxt_running = 1'b0; // [R20]
        end
        else if (go_event)
        begin
            nxt_running = 1'b1;
            nxt_count = preset_ff;
        end
        else if (expiring && config_ff[RELOAD_BIT])
        begin
            nxt_count = preset_ff; // [R17]
        end
        else if (expiring)
        begin
            nxt_count = '0; // [R16]
            nxt_running = 1'b0;
        end
        else if (running_ff && tick)
        begin
            nxt_count = count_ff - COUNT_W'(1);
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            count_ff <= '0;
            running_ff <= 1'b0;
        end
        else
        begin
            count_ff <= nxt_count;
            running_ff <= nxt_running;
        end
    end

    // Expiry is flagged sticky; writing one to the flag clears it, but a new
    // expiry in the same cycle wins.
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            expired_sticky_ff <= 1'b0;
            expire_pulse_ff <= 1'b0;
        end
        else
        begin
            expire_pulse_ff <= expiring && !halt_event && !go_event
                && config_ff[ENABLE_BIT]; // [R19]
            if (expiring && !halt_event && !go_event && config_ff[ENABLE_BIT])
            begin
                expired_sticky_ff <= 1'b1;
            end
            else if (wr_access && paddr == ADDR_STATUS && pwdata[STAT_EXPIRED_BIT])
            begin
                expired_sticky_ff <= 1'b0;
            end
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign timer_running = running_ff;
    assign timer_expired = expire_pulse_ff;
    assign timer_value = count_ff;

    default clocking chk_clk @(posedge clock);
    endclocking
    default disable iff (rst);

    chk_halt_wins: assert property ( // [R20]
        config_ff[ENABLE_BIT] && halt_event && go_event |=> !running_ff)
        else $error("Stop event did not win over start event.");
    chk_go_loads: assert property ( // [R13]
        config_ff[ENABLE_BIT] && !halt_event && go_event
        |=> running_ff && count_ff == $past(preset_ff))
        else $error("Start event did not load preset and run.");
    chk_one_shot: assert property ( // [R16]
        expiring && !config_ff[RELOAD_BIT] && !halt_event && !go_event
        && config_ff[ENABLE_BIT] |=> !running_ff && count_ff == '0)
        else $error("One-shot expiry did not stop at zero.");
    chk_reload_run: assert property ( // [R17]
        expiring && config_ff[RELOAD_BIT] && !halt_event && !go_event
        && config_ff[ENABLE_BIT] |=> running_ff && count_ff == $past(preset_ff))
        else $error("Reload expiry did not reload preset.");
    chk_disabled_idle: assert property (!config_ff[ENABLE_BIT] |=> !running_ff) // [R18]
        else $error("Timer ran while disabled.");
    chk_expiry_flag: assert property (timer_expired |-> expired_sticky_ff) // [R19]
        else $error("Expiry pulse without sticky flag.");
    chk_set_wins: assert property ( // [R19]
        expiring && !halt_event && !go_event && config_ff[ENABLE_BIT]
        |=> expired_sticky_ff && timer_expired)
        else $error("Expiry was not flagged in status.");
    chk_ext_halt: assert property ( // [R3]
        config_ff[ENABLE_BIT] && config_ff[HALT_EXT_ON_BIT] && $rose(external_field)
        |=> !running_ff)
        else $error("External field on did not halt timer.");
    chk_tx_halt: assert property ( // [R2]
        config_ff[ENABLE_BIT] && config_ff[HALT_TX_BEGIN_BIT] && tx_begin |=> !running_ff)
        else $error("Transmit begin did not halt timer.");
    chk_rx_halt: assert property ( // [R1]
        config_ff[ENABLE_BIT] && config_ff[HALT_RX_BEGIN_BIT] && rx_four_bits |=> !running_ff)
        else $error("Four received bits did not halt timer.");
    chk_own_go: assert property ( // [R12]
        config_ff[ENABLE_BIT] && config_ff[GO_OWN_ON_BIT] && own_on && !halt_event
        |=> running_ff && count_ff == $past(preset_ff))
        else $error("Own field on did not start timer.");
    chk_fast_count: assert property ( // [R15]
        running_ff && !config_ff[SOURCE_SEL_BIT] && cl_rise && !halt_event && !go_event
        && !expiring && config_ff[ENABLE_BIT] |=> count_ff == $past(count_ff) - COUNT_W'(1))
        else $error("Direct source tick did not decrement.");
    chk_div_count: assert property ( // [R14]
        running_ff && config_ff[SOURCE_SEL_BIT] && div_tick && !halt_event && !go_event
        && !expiring && config_ff[ENABLE_BIT] |=> count_ff == $past(count_ff) - COUNT_W'(1))
        else $error("Divided tick did not decrement.");
    chk_hold_no_tick: assert property ( // [R14]
        running_ff && !tick && !halt_event && !go_event && config_ff[ENABLE_BIT]
        |=> $stable(count_ff))
        else $error("Counter moved without a tick.");
    // The slave answers in the first access cycle and only for one cycle.
    chk_apb_answer: assert property (setup_phase |=> pready_ff)
        else $error("APB answer not ready in first access cycle.");
    chk_pready_pulse: assert property (pready_ff |=> !pready_ff)
        else $error("APB ready stood for more than one cycle.");

    cov_expire_once: cover property (expiring && !config_ff[RELOAD_BIT]);
    cov_reload: cover property (expiring && config_ff[RELOAD_BIT] ##1 running_ff);
    cov_clash: cover property (halt_event && go_event && config_ff[ENABLE_BIT]);
    cov_divided: cover property (div_tick && config_ff[SOURCE_SEL_BIT] && running_ff);
    cov_halt_run: cover property (running_ff && halt_event && config_ff[ENABLE_BIT]);
endmodule

// File: src/ret_pkg.sv
// Constants for the second configurable event timer of the contactless frontend.
// Assumes a 200 MHz system clock and a 13.56 MHz contactless clock arriving on a pin.
package ret_pkg;
    // Register byte addresses on the APB bus.
    localparam logic [7:0] ADDR_CONFIG = 8'h10;
    localparam logic [7:0] ADDR_PRESET = 8'h14;
    localparam logic [7:0] ADDR_VALUE = 8'h18;
    localparam logic [7:0] ADDR_STATUS = 8'h1C;
    // Field positions of the configuration register.
    localparam int HALT_RX_BEGIN_BIT = 20;
    localparam int HALT_TX_BEGIN_BIT = 19;
    localparam int HALT_EXT_ON_BIT = 18;
    localparam int HALT_EXT_OFF_BIT = 17;
    localparam int HALT_OWN_ON_BIT = 16;
    localparam int HALT_OWN_OFF_BIT = 15;
    localparam int GO_RX_BEGIN_BIT = 14;
    localparam int GO_RX_END_BIT = 13;
    localparam int GO_TX_BEGIN_BIT = 12;
    localparam int GO_TX_END_BIT = 11;
    localparam int GO_EXT_ON_BIT = 10;
    localparam int GO_EXT_OFF_BIT = 9;
    localparam int GO_OWN_ON_BIT = 8;
    localparam int GO_OWN_OFF_BIT = 7;
    localparam int GO_NOW_BIT = 6;
    localparam int DIV_SEL_HI = 5;
    localparam int DIV_SEL_LO = 3;
    localparam int SOURCE_SEL_BIT = 2;
    localparam int RELOAD_BIT = 1;
    localparam int ENABLE_BIT = 0;
    // Writable bits of the configuration register; the rest read as zero.
    localparam logic [31:0] CONFIG_MASK = 32'h001F_FFFF;
    // Status register fields.
    localparam int STAT_RUNNING_BIT = 0;
    localparam int STAT_EXPIRED_BIT = 1;
    // Reset values.
    localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
    localparam logic [31:0] PRESET_RESET = 32'h0000_0000;
    // Default width of the down-counter.
    localparam int COUNT_W_DEFAULT = 20;
    // Width of the prescaler counter: eight halving steps below 13.56 MHz.
    localparam int DIV_W = 8;
    // Contactless clock, in kHz, and system clock period, in ns.
    localparam int CL_CLOCK_KHZ = 13560;
    localparam int SYS_PERIOD_NS = 5;
endpackage

// File: bench/ret_timer_two_tb.sv
// Self-checking bench for the second event timer: APB register tasks and event sequences.
// Assumes an APB slave that may insert wait states and a free-running 13.56 MHz pin.
module ret_timer_two_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import ret_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic pready, pslverr, err, timer_running, timer_expired;
    logic cl_clk = 1'b0;
    logic rx_first_bit = 1'b0;
    logic rx_four_bits = 1'b0;
    logic rx_done = 1'b0;
    logic tx_begin = 1'b0;
    logic tx_done = 1'b0;
    logic external_field = 1'b0;
    logic own_field = 1'b0;
    logic [19:0] timer_value;
    int err_count = 0;
    int samples_checked = 0;
    int n;
    int halt_ev[6] = '{8, 2, 4, 5, 6, 7};
    real want;

    ret_timer_two #(.COUNT_W(20)) i_dut (.clock(clock), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .contactless_interface_clock(cl_clk),
        .rx_first_bit(rx_first_bit), .rx_four_bits(rx_four_bits), .rx_done(rx_done),
        .tx_begin(tx_begin), .tx_done(tx_done), .external_field(external_field),
        .own_field(own_field), .timer_running(timer_running), .timer_expired(timer_expired),
        .timer_value(timer_value));

    initial
    begin
        forever #2.5 clock = ~clock;
    end

    // The contactless clock starts at an odd offset so its phase is unrelated to clock.
    initial
    begin
        #3.1;
        forever #36.873 cl_clk = ~cl_clk;
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do
        begin
            @(posedge clock);
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic cfg(input logic [31:0] v);
        apb(1'b1, ADDR_CONFIG, v);
    endtask

    // Stops the timer and puts each field at the level opposite to the edge event e needs.
    task automatic prep(input int e);
        cfg(32'h0000_0000);
        external_field <= (e == 5);
        own_field <= (e == 7);
        repeat (3) @(posedge clock);
    endtask

    task automatic fire(input int e);
        @(posedge clock);
        case (e)
            0: rx_first_bit <= 1'b1;
            1: rx_done <= 1'b1;
            2: tx_begin <= 1'b1;
            3: tx_done <= 1'b1;
            4, 5: external_field <= (e == 4);
            6, 7: own_field <= (e == 6);
            default: rx_four_bits <= 1'b1;
        endcase
        @(posedge clock);
        rx_first_bit <= 1'b0;
        rx_done <= 1'b0;
        tx_begin <= 1'b0;
        tx_done <= 1'b0;
        rx_four_bits <= 1'b0;
    endtask

    task automatic wait_run(input logic v);
        int t;
        t = 0;
        do
        begin
            @(posedge clock);
            t++;
        end
        while (timer_running !== v && t < 6);
    endtask

    task automatic wait_exp();
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (timer_expired !== 1'b1 && n < 20000);
        check("expiry pulse", 32'(timer_expired), 32'h0000_0001);
    endtask

    initial
    begin
        repeat (60000) @(posedge clock);
        err_count++;
        print_verdict();
    end

    initial
    begin
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        apb(1'b0, ADDR_CONFIG, 32'h0000_0000);
        check("config reset", rd, CONFIG_RESET);
        cfg(32'hFFFF_FFFE);
        apb(1'b0, ADDR_CONFIG, 32'h0000_0000);
        check("config bits", rd, 32'h001F_FFFE);
        apb(1'b0, 8'h20, 32'h0000_0000);
        check("unmapped data", rd, 32'h0000_0000);
        check("unmapped error", 32'(err), 32'h0000_0001);
        apb(1'b1, ADDR_PRESET, 32'h0000_03E8);
        for (int k = 0; k < 8; k++)
        begin
            prep(k);
            cfg(32'(1 << (GO_RX_BEGIN_BIT - k)) | 32'h0000_0001);
            check("idle before event", 32'(timer_running), 32'h0000_0000);
            fire(k);
            wait_run(1'b1);
            check("go event", 32'(timer_running), 32'h0000_0001);
            check("preset loaded", 32'(timer_value), 32'h0000_03E8);
        end
        for (int j = 0; j < 6; j++)
        begin
            prep(halt_ev[j]);
            cfg(32'(1 << (HALT_RX_BEGIN_BIT - j)) | 32'h0000_0041);
            wait_run(1'b1);
            check("immediate start", 32'(timer_running), 32'h0000_0001);
            fire(halt_ev[j]);
            wait_run(1'b0);
            check("halt event", 32'(timer_running), 32'h0000_0000);
        end
        prep(2);
        cfg(32'h0000_1000);
        fire(2);
        repeat (4) @(posedge clock);
        check("disabled ignores", 32'(timer_running), 32'h0000_0000);
        prep(2);
        cfg(32'h0008_1001);
        fire(2);
        repeat (4) @(posedge clock);
        check("halt beats go", 32'(timer_running), 32'h0000_0000);
        prep(0);
        apb(1'b1, ADDR_PRESET, 32'h0000_0002);
        cfg(32'h0000_0041);
        wait_exp();
        check("one-shot stops", 32'(timer_running), 32'h0000_0000);
        check("one-shot zero", 32'(timer_value), 32'h0000_0000);
        apb(1'b0, ADDR_STATUS, 32'h0000_0000);
        check("expiry status", rd, 32'h0000_0002);
        apb(1'b1, ADDR_STATUS, 32'h0000_0002);
        apb(1'b0, ADDR_STATUS, 32'h0000_0000);
        check("status cleared", rd, 32'h0000_0000);
        apb(1'b1, ADDR_PRESET, 32'h0000_0003);
        cfg(32'h0000_0043);
        wait_exp();
        check("reload runs", 32'(timer_running), 32'h0000_0001);
        check("reload value", 32'(timer_value), 32'h0000_0003);
        // A second reset in mid-run must stop the timer and clear the configuration.
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        check("reset stops", 32'(timer_running), 32'h0000_0000);
        apb(1'b0, ADDR_CONFIG, 32'h0000_0000);
        check("config after reset", rd, CONFIG_RESET);
        apb(1'b0, ADDR_PRESET, 32'h0000_0000);
        check("preset after reset", rd, PRESET_RESET);
        apb(1'b1, ADDR_PRESET, 32'h0000_0002);
        // Two ticks per run; each tick spans one pin edge, or 2^(code+1) edges when divided.
        for (int c = -1; c < 8; c++)
        begin
            prep(0);
            cfg(c < 0 ? 32'h0000_0041 : (32'h0000_0045 | 32'(c << DIV_SEL_LO)));
            wait_exp();
            want = ((c < 0 ? 2.0 : 2.0 * (2 ** (c + 1))) - 0.5) * 14.749 + 4.0;
            check("tick rate", 32'(n > want - 12.0 && n < want + 12.0), 32'h0000_0001);
        end
        print_verdict();
    end
endmodule
